// >>> shared/ibpc_map.vh
/*
 * constant map of the expansion bus cycle generator: register offsets,
 * field positions, reset values and cycle timing counts.
 * assumes a 40 mhz system clock and a 32-bit axi4-lite register bus.
 */
`ifndef IBPC_MAP_VH
`define IBPC_MAP_VH

// ************************************************************
// register indices and byte addresses
// ************************************************************
`define IBPC_IDX_MODE       8'h01
`define IBPC_ADDR_MODE      8'h04
`define IBPC_ADDR_CTRL      8'h10
`define IBPC_ADDR_REQ       8'h14
`define IBPC_ADDR_WDATA     8'h18
`define IBPC_ADDR_STATUS    8'h1c
`define IBPC_ADDR_RDATA     8'h20

// ************************************************************
// mode register fields
// ************************************************************
`define IBPC_MODE_INHIBIT   2
`define IBPC_MODE_LATCH     3
`define IBPC_MODE_RESET     8'h00

// ************************************************************
// control register fields (hold, clamp)
// ************************************************************
`define IBPC_CTRL_HOLD      0
`define IBPC_CTRL_CLAMP     1

// ************************************************************
// request register fields
// ************************************************************
`define IBPC_REQ_ADDR_LSB   0
`define IBPC_REQ_ADDR_MSB   23
`define IBPC_REQ_WRITE      24
`define IBPC_REQ_IO         25
`define IBPC_REQ_WORD       26
`define IBPC_REQ_WIDE       27
`define IBPC_REQ_INTERNAL   28

// ************************************************************
// cycle timing, in ns and in clock cycles
// ************************************************************
`define IBPC_CLK_NS         25
`define IBPC_SETUP_NS       50
`define IBPC_STROBE_NS      200
`define IBPC_HOLD_NS        50
`define IBPC_CYC(ns)        (((ns) + `IBPC_CLK_NS - 1) / `IBPC_CLK_NS)
`define IBPC_SETUP_CYC      `IBPC_CYC(`IBPC_SETUP_NS)
`define IBPC_STROBE_CYC     `IBPC_CYC(`IBPC_STROBE_NS)
`define IBPC_HOLD_CYC       `IBPC_CYC(`IBPC_HOLD_NS)

`endif

// >>> logic/ibpc_data_pins.v
/*
 * data pin driver: write data, held data and stop-clock clamp.
 * assumes the cycle engine gives write enable, latch strobe and data.
 */
`timescale 1ns/10ps
`include "ibpc_map.vh"

module ibpc_data_pins #(
   parameter DW = 16
) (
   // clock and reset
   input  wire          clk,
   input  wire          rst_n,
   input  wire          ce,
   // controls
   input  wire          hold_en,
   input  wire          clamp_en,
   input  wire          stop_clock,
   input  wire          cycle_busy,
   input  wire          drive_write,
   input  wire          latch_now,
   input  wire [DW-1:0] latch_value,
   input  wire [DW-1:0] write_value,
   // pins
   output reg  [DW-1:0] data_out,
   output reg           data_oe
);

   reg [DW-1:0] held;
   reg          held_valid;

   // ************************************************************
   // latch at end of each transfer
   // ************************************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         held       <= {DW{1'b0}};
         held_valid <= 1'b0;
      end else if (ce && latch_now) begin
         held       <= latch_value;
         held_valid <= 1'b1;
      end
   end

   // ************************************************************
   // pin drive priority
   // ************************************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_out <= {DW{1'b0}};
         data_oe  <= 1'b0;
      end else if (ce) begin
         if (clamp_en && stop_clock) begin
            data_out <= {DW{1'b0}};
            data_oe  <= 1'b1;
         end else if (drive_write) begin
            data_out <= write_value;
            data_oe  <= 1'b1;
         end else if (hold_en && held_valid && !cycle_busy) begin
            data_out <= held;
            data_oe  <= 1'b1;
         end else begin
            data_out <= {DW{1'b0}};
            data_oe  <= 1'b0;
         end
      end
   end

endmodule // ibpc_data_pins

// >>> logic/ibpc_bus_cycle_generator.v
/*
 * expansion bus cycle generator with bus power saving options and an
 * axi4-lite register slave. software posts a request, the block runs
 * one 8- or 16-bit io or memory cycle on the pins, or two byte cycles for a word to an 8-bit target.
 * assumes one synchronous clock; peripheral inputs synchronous to clk.
 */
// Contract
// - inhibit mode: internal io accesses leave data pins and io strobes idle
// - inhibit mode enabled by mode register bit 2 at index 01h
// - latching mode: only needed address bits change, others keep old
// - latching mode enabled by mode register bit 3 at index 01h
// - data pins are inputs by default, driven only during writes
// - hold mode latches transfer data and drives it until next cycle
// - clamp drives data pins low during stop-clock states until exit
// - ready low from the peripheral stretches the current cycle
// - io write: device drives data while io write strobe is low
// - memory read: memory read strobe low while memory drives data
// - memory write: device drives data with memory write strobe low
// - both 8-bit and 16-bit expansion cycles are generated
// - latching io cycles keep upper address bits instead of low
// - word access to 8-bit target becomes two low-lane byte transfers
`timescale 1ns/10ps
`include "ibpc_map.vh"

module ibpc_bus_cycle_generator #(
   parameter AW = 24,
   parameter DW = 16
) (
   // clock and reset
   input  wire          clk,
   input  wire          resetn,
   input  wire          ce,
   // axi4-lite slave
   input  wire [7:0]    s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output wire          s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output wire          s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [7:0]    s_axi_araddr,
   input  wire          s_axi_arvalid,
   output wire          s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   // power state
   input  wire          stop_clock,
   // expansion bus pins
   output reg  [AW-1:0] addr,
   input  wire [DW-1:0] data_in,
   output wire [DW-1:0] data_out,
   output wire          data_oe,
   output reg           io_read_strobe_n,
   output reg           io_write_strobe_n,
   output reg           mem_read_strobe_n,
   output reg           mem_write_strobe_n,
   input  wire          channel_ready
);

   localparam ST_IDLE  = 3'd0;
   localparam ST_SETUP = 3'd1;
   localparam ST_STRB  = 3'd2;
   localparam ST_HOLD  = 3'd3;
   localparam ST_NEXT  = 3'd4;
   localparam ST_INT   = 3'd5;
   localparam [7:0] SETUP_CYC  = `IBPC_SETUP_CYC;
   localparam [7:0] STROBE_CYC = `IBPC_STROBE_CYC;
   localparam [7:0] HOLD_CYC   = `IBPC_HOLD_CYC;

   // ************************************************************
   // reset release
   // ************************************************************
   reg [1:0] rst_sync;
   wire      rst_n = rst_sync[1];
   always @(posedge clk or negedge resetn) begin
      if (!resetn)
         rst_sync <= 2'b00;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end

   // ************************************************************
   // registers
   // ************************************************************
   reg [7:0]    mode;
   reg [1:0]    ctrl;
   reg [31:0]   req;
   reg [DW-1:0] wdata;
   reg [DW-1:0] rdata;
   reg          busy;
   reg          done;
   reg          aw_held;
   reg          w_held;
   reg [7:0]    aw_addr;
   reg [31:0]   w_data;
   reg [2:0]    state;
   reg [7:0]    count;
   reg          second;
   reg          drive_write;
   wire latch_now = (state == ST_STRB) && (count <= 8'h01) && channel_ready;
   reg          start;

   wire inhibit = mode[`IBPC_MODE_INHIBIT];
   wire latching = mode[`IBPC_MODE_LATCH];
   wire r_write = req[`IBPC_REQ_WRITE];
   wire r_io = req[`IBPC_REQ_IO];
   wire r_word = req[`IBPC_REQ_WORD];
   wire r_wide = req[`IBPC_REQ_WIDE];
   wire [AW-1:0] r_addr = req[`IBPC_REQ_ADDR_MSB:`IBPC_REQ_ADDR_LSB];
   wire split = r_word && !r_wide;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `IBPC_ADDR_MODE) || (a == `IBPC_ADDR_CTRL) ||
                  (a == `IBPC_ADDR_REQ) || (a == `IBPC_ADDR_WDATA) ||
                  (a == `IBPC_ADDR_STATUS) || (a == `IBPC_ADDR_RDATA);
      end
   endfunction

   // ************************************************************
   // axi write side
   // ************************************************************
   wire aw_now = aw_held || (s_axi_awvalid && s_axi_awready);
   wire w_now = w_held || (s_axi_wvalid && s_axi_wready);
   wire [7:0] wa = aw_held ? aw_addr : s_axi_awaddr;
   wire [31:0] wd = w_held ? w_data : s_axi_wdata;
   wire do_write = aw_now && w_now && !s_axi_bvalid;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
         mode         <= `IBPC_MODE_RESET;
         ctrl         <= 2'b00;
         req          <= 32'h0000_0000;
         wdata        <= {DW{1'b0}};
         start        <= 1'b0;
      end else if (ce) begin
         start <= 1'b0;
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(wa) ? 2'b00 : 2'b10;
            if (wa == `IBPC_ADDR_MODE && s_axi_wstrb[0])
               mode <= wd[7:0];
            if (wa == `IBPC_ADDR_CTRL && s_axi_wstrb[0])
               ctrl <= wd[1:0];
            if (wa == `IBPC_ADDR_WDATA)
               wdata <= wd[DW-1:0];
            if (wa == `IBPC_ADDR_REQ && !busy) begin
               req   <= wd;
               start <= 1'b1;
            end
         end else begin
            if (s_axi_awvalid && s_axi_awready) begin
               aw_held <= 1'b1;
               aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
               w_held <= 1'b1;
               w_data <= s_axi_wdata;
            end
         end
      end
   end

   // ************************************************************
   // axi read side
   // ************************************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else if (ce) begin
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
            case (s_axi_araddr)
               `IBPC_ADDR_MODE:   s_axi_rdata <= {24'h000000, mode};
               `IBPC_ADDR_CTRL:   s_axi_rdata <= {30'h0, ctrl};
               `IBPC_ADDR_REQ:    s_axi_rdata <= req;
               `IBPC_ADDR_WDATA:  s_axi_rdata <= {16'h0000, wdata};
               `IBPC_ADDR_STATUS: s_axi_rdata <= {30'h0, done, busy};
               `IBPC_ADDR_RDATA:  s_axi_rdata <= {16'h0000, rdata};
               default:           s_axi_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ************************************************************
   // cycle engine
   // ************************************************************
   wire lane_hi = !split && !r_word && r_addr[0] && r_wide;
   wire [AW-1:0] cyc_addr = split ? {r_addr[AW-1:1], second} : r_addr;
   wire [DW-1:0] wr_lane = split ? (second ? {8'h00, wdata[15:8]}
                                           : {8'h00, wdata[7:0]})
                         : (lane_hi ? {wdata[7:0], 8'h00} : wdata);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state              <= ST_IDLE;
         count              <= 8'h00;
         second             <= 1'b0;
         busy               <= 1'b0;
         done               <= 1'b0;
         rdata              <= {DW{1'b0}};
         addr               <= {AW{1'b0}};
         drive_write        <= 1'b0;
         io_read_strobe_n   <= 1'b1;
         io_write_strobe_n  <= 1'b1;
         mem_read_strobe_n  <= 1'b1;
         mem_write_strobe_n <= 1'b1;
      end else if (ce) begin
         case (state)
            ST_IDLE: begin
               if (start) begin
                  busy   <= 1'b1;
                  done   <= 1'b0;
                  second <= 1'b0;
                  if (r_io && req[`IBPC_REQ_INTERNAL] && inhibit)
                     state <= ST_INT;
                  else
                     state <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               if (latching && r_io)
                  addr <= {addr[AW-1:16], cyc_addr[15:0]};
               else if (latching)
                  addr <= {cyc_addr[AW-1:1],
                           split ? second : cyc_addr[0]};
               else if (r_io)
                  addr <= {{(AW-16){1'b0}}, cyc_addr[15:0]};
               else
                  addr <= cyc_addr;
               drive_write <= r_write;
               count <= SETUP_CYC;
               state <= ST_SETUP;
            end
            ST_SETUP: begin
               if (count > 8'h01)
                  count <= count - 8'h01;
               else begin
                  io_read_strobe_n   <= !(r_io && !r_write);
                  io_write_strobe_n  <= !(r_io && r_write);
                  mem_read_strobe_n  <= !(!r_io && !r_write);
                  mem_write_strobe_n <= !(!r_io && r_write);
                  count <= STROBE_CYC;
                  state <= ST_STRB;
               end
            end
            ST_STRB: begin
               if (count > 8'h01)
                  count <= count - 8'h01;
               else if (channel_ready) begin
                  io_read_strobe_n   <= 1'b1;
                  io_write_strobe_n  <= 1'b1;
                  mem_read_strobe_n  <= 1'b1;
                  mem_write_strobe_n <= 1'b1;
                  if (!r_write) begin
                     if (split && second)
                        rdata[15:8] <= data_in[7:0];
                     else if (split || (!r_word && !lane_hi))
                        rdata <= {8'h00, data_in[7:0]};
                     else if (lane_hi)
                        rdata <= {8'h00, data_in[15:8]};
                     else
                        rdata <= data_in;
                  end
                  count <= HOLD_CYC;
                  state <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (count > 8'h01)
                  count <= count - 8'h01;
               else begin
                  drive_write <= 1'b0;
                  if (split && !second) begin
                     second <= 1'b1;
                     state  <= ST_NEXT;
                  end else begin
                     busy  <= 1'b0;
                     done  <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
            end
            ST_INT: begin
               busy  <= 1'b0;
               done  <= 1'b1;
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ************************************************************
   // data pins
   // ************************************************************
   wire [DW-1:0] latch_value = r_write ? wr_lane : data_in;

   ibpc_data_pins #(
      .DW (DW)
   ) u_data (
      .clk         (clk),
      .rst_n       (rst_n),
      .ce          (ce),
      .hold_en     (ctrl[`IBPC_CTRL_HOLD]),
      .clamp_en    (ctrl[`IBPC_CTRL_CLAMP]),
      .stop_clock  (stop_clock),
      .cycle_busy  (busy && state != ST_INT),
      .drive_write (drive_write),
      .latch_now   (latch_now),
      .latch_value (latch_value),
      .write_value (wr_lane),
      .data_out    (data_out),
      .data_oe     (data_oe)
   );

endmodule // ibpc_bus_cycle_generator

// >>> verif/ibpc_props.sv
/* port checks for the bus cycle generator.
   assumes ibpc_map.vh and one clock domain. */
`timescale 1ns/10ps
`include "ibpc_map.vh"

module ibpc_props #(
   parameter AW = 24,
   parameter DW = 16
) (
   // clock and reset
   input wire          clk,
   input wire          resetn,
   // register bus
   input wire [7:0]    s_axi_awaddr,
   input wire          s_axi_awvalid,
   input wire          s_axi_awready,
   input wire [31:0]   s_axi_wdata,
   input wire          s_axi_wvalid,
   input wire          s_axi_wready,
   input wire [1:0]    s_axi_bresp,
   input wire          s_axi_bvalid,
   input wire          s_axi_bready,
   // pins
   input wire          stop_clock,
   input wire [AW-1:0] addr,
   input wire [DW-1:0] data_out,
   input wire          data_oe,
   input wire          io_read_strobe_n,
   input wire          io_write_strobe_n,
   input wire          mem_read_strobe_n,
   input wire          mem_write_strobe_n,
   input wire          channel_ready
);
   // ************
   // shadow state
   // ************
   reg [7:0]  aw_q, mode_q, upper_q;
   reg [31:0] w_q;
   reg [1:0]  ctrl_q;
   reg [4:0]  inh_cnt;
   wire io_act = ~(io_read_strobe_n & io_write_strobe_n);
   wire act    = io_act | ~(mem_read_strobe_n & mem_write_strobe_n);
   wire wr_ok  = s_axi_bvalid & s_axi_bready & (s_axi_bresp == 2'b00);
   wire req_ok = wr_ok && aw_q == `IBPC_ADDR_REQ;

   always @(posedge clk or negedge resetn) begin
      if (!resetn)
         {aw_q, mode_q, upper_q, w_q, ctrl_q, inh_cnt} <= 63'h0;
      else begin
         if (s_axi_awvalid && s_axi_awready)
            aw_q <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready)
            w_q <= s_axi_wdata;
         if (wr_ok && aw_q == `IBPC_ADDR_MODE)
            mode_q <= w_q[7:0];
         if (wr_ok && aw_q == `IBPC_ADDR_CTRL)
            ctrl_q <= w_q[1:0];
         if (req_ok)
            upper_q <= addr[23:16];
         if (req_ok && w_q[`IBPC_REQ_INTERNAL] && w_q[`IBPC_REQ_IO]
             && mode_q[`IBPC_MODE_INHIBIT])
            inh_cnt <= 5'h14;
         else if (inh_cnt != 5'h00)
            inh_cnt <= inh_cnt - 5'h01;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_low8;
      act [*8];
   endsequence
   sequence s_clamp3;
      (stop_clock && ctrl_q[`IBPC_CTRL_CLAMP]) [*3];
   endsequence

   a_strobe_len: assert property ($rose(act) |-> s_low8)
      else $error("strobe shorter than eight cycles");
   a_ready_hold: assert property (act && !channel_ready |=> act)
      else $error("strobe ended while ready low");
   a_read_float: assert property ((!io_read_strobe_n ||
      !mem_read_strobe_n) && !stop_clock |-> !data_oe)
      else $error("data driven during read");
   a_write_drive: assert property ((!io_write_strobe_n ||
      !mem_write_strobe_n) |-> data_oe)
      else $error("data not driven during write");
   a_inhibit_io: assert property (inh_cnt != 5'h00 |-> !io_act)
      else $error("io strobe on internal access");
   a_latch_upper: assert property (io_act && mode_q[3]
      |-> addr[23:16] == upper_q)
      else $error("upper address moved while latching");
   a_io_upper_low: assert property (io_act && !mode_q[3]
      |-> addr[23:16] == 8'h00)
      else $error("upper address not low in io cycle");
   a_clamp_low: assert property (s_clamp3
      |-> data_oe && data_out == 16'h0000)
      else $error("data not clamped low");
endmodule // ibpc_props

bind ibpc_bus_cycle_generator ibpc_props #(.AW(AW), .DW(DW)) u_props (
   .clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .stop_clock, .addr, .data_out, .data_oe,
   .io_read_strobe_n, .io_write_strobe_n, .mem_read_strobe_n,
   .mem_write_strobe_n, .channel_ready);

// >>> verif/ibpc_isa_peer.sv
/* on-board peripheral model: sixteen words for io and memory cycles.
   assumes active-low strobes and a stall count from the bench. */
`timescale 1ns/10ps

module ibpc_isa_peer (
   // clock
   input  wire        clk,
   // bus from the generator
   input  wire [23:0] addr,
   input  wire [15:0] data_out,
   input  wire        data_oe,
   input  wire        io_read_strobe_n,
   input  wire        io_write_strobe_n,
   input  wire        mem_read_strobe_n,
   input  wire        mem_write_strobe_n,
   // answers
   input  wire [4:0]  stall,
   output wire [15:0] data_in,
   output wire        channel_ready
);
   reg [15:0] mem [0:15];
   reg [15:0] idle_q;
   reg [4:0]  wait_cnt;
   reg        seen;
   integer    i;
   wire rd = ~(io_read_strobe_n & mem_read_strobe_n);
   wire wr = ~(io_write_strobe_n & mem_write_strobe_n);
   // released bus toggles, no pull
   assign data_in = rd ? mem[addr[3:0]] : idle_q;
   assign channel_ready = (wait_cnt == 5'h00);

   initial begin
      for (i = 0; i < 16; i = i + 1)
         mem[i] = 16'h1000 + i[15:0];
      idle_q = 16'h5a5a;
      wait_cnt = 5'h00;
      seen = 1'b0;
   end

   always @(posedge clk) begin
      idle_q <= ~idle_q;
      if (wr && data_oe)
         mem[addr[3:0]] <= data_out;
      if ((rd || wr) && !seen)
         wait_cnt <= stall;
      else if (wait_cnt != 5'h00)
         wait_cnt <= wait_cnt - 5'h01;
      seen <= rd || wr;
   end
endmodule // ibpc_isa_peer

// >>> verif/tb_ibpc_bus_cycle_generator.sv
/* self-checking bench for the bus cycle generator.
   assumes ibpc_map.vh, the peripheral model and a 40 mhz clock. */
`timescale 1ns/10ps
`include "ibpc_map.vh"

module tb_ibpc_bus_cycle_generator;
   reg         clk, resetn, ce, stop_clock;
   reg  [7:0]  s_axi_awaddr, s_axi_araddr;
   reg  [31:0] s_axi_wdata;
   reg  [3:0]  s_axi_wstrb;
   reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   reg         s_axi_arvalid, s_axi_rready;
   reg  [4:0]  stall;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire        s_axi_arready, s_axi_rvalid, data_oe, channel_ready;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [23:0] addr;
   wire [15:0] data_in, data_out;
   wire        io_read_strobe_n, io_write_strobe_n;
   wire        mem_read_strobe_n, mem_write_strobe_n;
   reg  [31:0] rd;
   reg  [1:0]  rs;
   integer     mismatches = 0, checked = 0, run = 0, last_len = 0;
   integer     xfers = 0, n0;
   wire act = ~(io_read_strobe_n & io_write_strobe_n
                & mem_read_strobe_n & mem_write_strobe_n);

   ibpc_bus_cycle_generator uut (
      .clk, .resetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .stop_clock, .addr, .data_in,
      .data_out, .data_oe, .io_read_strobe_n, .io_write_strobe_n,
      .mem_read_strobe_n, .mem_write_strobe_n, .channel_ready);
   ibpc_isa_peer peer (
      .clk, .addr, .data_out, .data_oe, .io_read_strobe_n,
      .io_write_strobe_n, .mem_read_strobe_n, .mem_write_strobe_n,
      .stall, .data_in, .channel_ready);

   // *****************
   // clock and helpers
   // *****************
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      #100000;
      mismatches = mismatches + 1;
      close_out;
   end
   always @(posedge clk) begin
      if (act)
         run <= run + 1;
      else if (run != 0) begin
         last_len <= run;
         xfers <= xfers + 1;
         run <= 0;
      end
   end

   task check(input [31:0] seen, input [31:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
         end
      end
   endtask
   task close_out;
      begin
         $display("checks %0d mismatches %0d", checked, mismatches);
         if (mismatches == 0 && checked > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   task axi_write(input [7:0] a, input [31:0] d, output [1:0] r);
      begin
         @(posedge clk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
         do begin
            @(posedge clk);
            if (s_axi_awready)
               s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
               s_axi_wvalid <= 1'b0;
         end while (s_axi_bvalid !== 1'b1);
         r = s_axi_bresp;
         s_axi_bready <= 1'b0;
      end
   endtask
   task axi_read(input [7:0] a, output [31:0] d, output [1:0] r);
      begin
         @(posedge clk);
         s_axi_araddr <= a;
         {s_axi_arvalid, s_axi_rready} <= 2'h3;
         do begin
            @(posedge clk);
            if (s_axi_arready)
               s_axi_arvalid <= 1'b0;
         end while (s_axi_rvalid !== 1'b1);
         d = s_axi_rdata;
         r = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask
   task run_req(input [31:0] q);
      begin
         axi_write(`IBPC_ADDR_REQ, q, rs);
         do
            axi_read(`IBPC_ADDR_STATUS, rd, rs);
         while (rd[0] !== 1'b0);
      end
   endtask

   // *********
   // scenarios
   // *********
   task t_regs;
      begin
         check(data_oe, 1'b0);
         axi_read(`IBPC_ADDR_MODE, rd, rs);
         check(rd[7:0], `IBPC_MODE_RESET);
         axi_write(`IBPC_ADDR_MODE, 32'h0000000c, rs);
         axi_read(`IBPC_ADDR_MODE, rd, rs);
         check(rd[7:0], 8'h0c);
         axi_read(8'h3c, rd, rs);
         check(rs, 2'b10);
         axi_write(8'h3c, 32'h0000ffff, rs);
         check(rs, 2'b10);
         axi_write(`IBPC_ADDR_MODE, 32'h00000000, rs);
      end
   endtask
   task t_io;
      begin
         axi_write(`IBPC_ADDR_WDATA, 32'h0000a55a, rs);
         run_req(32'h0f012304);
         check(peer.mem[4], 16'ha55a);
         check(last_len, `IBPC_STROBE_CYC);
         check(addr, 24'h002304);
         axi_write(`IBPC_ADDR_WDATA, 32'h00001234, rs);
         run_req(32'h0d4a0006);
         check(peer.mem[6], 16'h1234);
         stall <= 5'h0c;
         run_req(32'h0c4a0006);
         axi_read(`IBPC_ADDR_RDATA, rd, rs);
         check(rd[15:0], 16'h1234);
         check(last_len >= 12, 1'b1);
         stall <= 5'h00;
         axi_write(`IBPC_ADDR_MODE, 32'h00000008, rs);
         run_req(32'h0e000002);
         axi_read(`IBPC_ADDR_RDATA, rd, rs);
         check(rd[15:0], 16'h1002);
         check(addr[23:16], 8'h4a);
      end
   endtask
   task t_split;
      begin
         axi_write(`IBPC_ADDR_WDATA, 32'h0000beef, rs);
         n0 = xfers;
         run_req(32'h05000008);
         check(xfers - n0, 2);
         check(peer.mem[8][7:0], 8'hef);
         check(peer.mem[9][7:0], 8'hbe);
      end
   endtask
   task t_inhibit;
      begin
         axi_write(`IBPC_ADDR_MODE, 32'h00000004, rs);
         n0 = xfers;
         run_req(32'h13000010);
         check(xfers - n0, 0);
         check(data_oe, 1'b0);
      end
   endtask
   task t_hold;
      begin
         axi_write(`IBPC_ADDR_CTRL, 32'h00000001, rs);
         run_req(32'h0c000006);
         check({data_oe, data_out}, 17'h11234);
         axi_write(`IBPC_ADDR_CTRL, 32'h00000003, rs);
         stop_clock <= 1'b1;
         repeat (4) @(posedge clk);
         check({data_oe, data_out}, 17'h10000);
         stop_clock <= 1'b0;
         repeat (4) @(posedge clk);
         check({data_oe, data_out}, 17'h11234);
      end
   endtask

   initial begin
      resetn = 1'b0;
      ce = 1'b1;
      stop_clock = 1'b0;
      stall = 5'h00;
      s_axi_wstrb = 4'hf;
      s_axi_wdata = 32'h00000000;
      {s_axi_awaddr, s_axi_araddr} = 16'h0000;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs;
      t_io;
      t_split;
      t_inhibit;
      t_hold;
      close_out;
   end
endmodule // tb_ibpc_bus_cycle_generator
